/* File: core/adcsq_pkg.sv */
// Constants and types shared by the conversion sequencer
package adcsq_pkg;

  // Register byte offsets on the APB side
  localparam logic [7:0] OFS_STATUS_CONTROL_ONE = 8'h00;
  localparam logic [7:0] OFS_STATUS_CONTROL_TWO = 8'h04;
  localparam logic [7:0] OFS_RESULT_HIGH        = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW         = 8'h0C;
  localparam logic [7:0] OFS_COMPARE_VALUE_HIGH = 8'h10;
  localparam logic [7:0] OFS_COMPARE_VALUE_LOW  = 8'h14;
  localparam logic [7:0] OFS_CONVERTER_CONFIG   = 8'h18;

  // Field positions of status_control_one
  localparam int SC1_DONE_BIT   = 7;
  localparam int SC1_IRQ_EN_BIT = 6;
  localparam int SC1_CONT_BIT   = 5;
  // Field positions of status_control_two
  localparam int SC2_ACTIVE_BIT = 7;
  localparam int SC2_TRIG_BIT   = 6;
  localparam int SC2_CMP_EN_BIT = 5;
  localparam int SC2_CMP_UP_BIT = 4;

  // Reset values and the channel-off code
  localparam logic [4:0] CHANNEL_RESET = 5'h1F;
  localparam logic [4:0] CHANNEL_OFF   = 5'h1F;
  localparam logic [7:0] CONFIG_RESET  = 8'h00;

  // Resolution encodings of the mode field
  localparam logic [1:0] MODE_8BIT  = 2'h0;
  localparam logic [1:0] MODE_12BIT = 2'h1;
  localparam logic [1:0] MODE_10BIT = 2'h2;

  // Input clock select encodings
  localparam logic [1:0] ICLK_BUS      = 2'h0;
  localparam logic [1:0] ICLK_BUS_DIV2 = 2'h1;
  localparam logic [1:0] ICLK_ALT      = 2'h2;
  localparam logic [1:0] ICLK_ASYNC    = 2'h3;

  // Timing in conversion-clock cycles, bus cycles and nanoseconds
  localparam logic [5:0] SAMPLE_SHORT_CYC = 6'h04;
  localparam logic [5:0] SAMPLE_LONG_CYC  = 6'h18;
  localparam logic [5:0] APPROX_8BIT_CYC  = 6'h0D;
  localparam logic [5:0] APPROX_HI_CYC    = 6'h10;
  localparam logic [5:0] FIRST_EXTRA_CYC  = 6'h03;
  localparam logic [5:0] XFER_FIRST_CYC   = 6'h05;
  localparam logic [5:0] XFER_NEXT_CYC    = 6'h01;
  localparam int         SYS_CLK_PERIOD_NS   = 100;
  localparam int         ASYNC_STARTUP_NS    = 5000;
  localparam logic [5:0] ASYNC_STARTUP_CYC   = 6'(ASYNC_STARTUP_NS / SYS_CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_STARTUP,
    ST_SAMPLE,
    ST_APPROX,
    ST_XFER
  } adcsq_phase_t;

  typedef struct packed {
    logic         irq_en;
    logic         cont;
    logic [4:0]   channel;
    logic         done;
    logic         trig_sel;
    logic         cmp_en;
    logic         cmp_upper;
    logic [7:0]   config_reg;
    logic [3:0]   cv_high;
    logic [7:0]   cv_low;
    logic [11:0]  result;
    logic         block;
    adcsq_phase_t phase;
    logic [5:0]   cnt;
    logic         first;
    logic         half_tgl;
    logic [2:0]   div_cnt;
    logic         trg_s1;
    logic         trg_s2;
    logic         trg_s3;
    logic         alt_s1;
    logic         alt_s2;
    logic         alt_s3;
    logic         asy_s1;
    logic         asy_s2;
    logic         asy_s3;
    logic         pready;
    logic         pslverr;
    logic [31:0]  prdata;
    logic         done_irq;
    logic         sample_phase;
    logic         async_clk_en;
    logic         active;
  } adcsq_state_t;

endpackage : adcsq_pkg

/* File: core/adcsq_sequencer.sv */
// Conversion sequencer: APB registers, timing, compare and result transfer
`timescale 1ns/1ps

// Functional notes
// - Hardware trigger rising edge starts conversion
// - Trigger edge during conversion is ignored
// - Continuous series ignores edges after first
// - Resolution 12, 10 or 8 bit
// - Software trigger: status write starts conversion
// - Continuous mode restarts after each transfer
// - Completion stores result, sets done, interrupts
// - Half-read result blocks transfer in 10 or 12 bit mode, discards result
// - Blocked transfer restarts, except failed single compare
// - Status one write aborts, restarts with software trigger unless off
// - Other configuration writes abort conversion
// - Reset or stop without async clock aborts
// - Abort keeps last result; reset clears it
// - Idle until started; async clock enabled then
// - Sample phase short or long selectable
// - First conversion within stated cycle budget
// - Async clock adds startup time
// - Subsequent continuous conversions shorter
// - Compare by adding two's complement value
// - Compare true stores difference value
// - Compare false: no done, no store
// - Disabled in reset or channel all ones
// - Conversion clock divided by 1, 2, 4, 8
// - Round to 10 or 8 bits
module adcsq_sequencer
  import adcsq_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        hw_conversion_trigger,
  input  wire logic        alt_clk_in,
  input  wire logic        async_conv_clock,
  input  wire logic        stop_mode_req,
  input  wire logic [11:0] sar_code,
  output logic             done_irq,
  output logic             conv_active,
  output logic             sample_phase,
  output logic             async_clk_en,
  output logic      [4:0]  channel_out
);

  adcsq_state_t s_r;
  adcsq_state_t s_nxt;

  // Round the raw 12-bit code to the selected resolution, saturating at full scale
  function automatic logic [11:0] round_code(input logic [11:0] raw, input logic [1:0] mode);
    logic [12:0] sum;
    logic [11:0] res;
    sum = 13'h0000;
    res = raw;
    if (mode == MODE_10BIT)
    begin
      sum = {1'b0, raw} + 13'h0002;
      res = sum[12] ? 12'h3FF : {2'h0, sum[11:2]};
    end
    else if (mode == MODE_8BIT)
    begin
      sum = {1'b0, raw} + 13'h0008;
      res = sum[12] ? 12'h0FF : {4'h0, sum[11:4]};
    end
    return res;
  endfunction : round_code

  // Mask a value to the width of the selected resolution
  function automatic logic [11:0] res_mask(input logic [11:0] v, input logic [1:0] mode);
    logic [11:0] m;
    m = 12'hFFF;
    if (mode == MODE_10BIT)
      m = 12'h3FF;
    else if (mode == MODE_8BIT)
      m = 12'h0FF;
    return v & m;
  endfunction : res_mask

  // Load the counters for a new conversion; a first one pays the startup overhead
  function automatic adcsq_state_t launch(input adcsq_state_t st, input logic first_c);
    adcsq_state_t o;
    o = st;
    o.first = first_c;
    o.async_clk_en = (st.config_reg[1:0] == ICLK_ASYNC);
    if (first_c && st.config_reg[1:0] == ICLK_ASYNC)
    begin
      o.phase = ST_STARTUP;
      o.cnt   = ASYNC_STARTUP_CYC;
    end
    else
    begin
      o.phase = ST_SAMPLE;
      o.cnt   = (st.config_reg[4] ? SAMPLE_LONG_CYC : SAMPLE_SHORT_CYC)
              + (first_c ? FIRST_EXTRA_CYC : 6'h00);
    end
    return o;
  endfunction : launch

  // Stop the converter and put it in its lowest power state
  function automatic adcsq_state_t halt(input adcsq_state_t st);
    adcsq_state_t o;
    o = st;
    o.phase        = ST_IDLE;
    o.cnt          = 6'h00;
    o.first        = 1'b0;
    o.async_clk_en = 1'b0;
    return o;
  endfunction : halt

  logic        base_tick;
  logic        conv_tick;
  logic [2:0]  div_mask;
  logic [11:0] conv_val;
  logic [11:0] cmp_val;
  logic [11:0] diff_val;
  logic        cmp_ge;
  logic        cmp_ok;
  logic        trg_rise;
  logic        apb_acc;
  logic        apb_wr;
  logic        apb_rd;
  logic        busy;
  logic        wide_mode;

  always_comb
  begin
    s_nxt = s_r;
    busy  = (s_r.phase != ST_IDLE);
    wide_mode = (s_r.config_reg[3:2] != MODE_8BIT);

    s_nxt.trg_s1 = hw_conversion_trigger;
    s_nxt.trg_s2 = s_r.trg_s1;
    s_nxt.trg_s3 = s_r.trg_s2;
    s_nxt.alt_s1 = alt_clk_in;
    s_nxt.alt_s2 = s_r.alt_s1;
    s_nxt.alt_s3 = s_r.alt_s2;
    s_nxt.asy_s1 = async_conv_clock;
    s_nxt.asy_s2 = s_r.asy_s1;
    s_nxt.asy_s3 = s_r.asy_s2;
    trg_rise = s_r.trg_s2 & ~s_r.trg_s3;

    s_nxt.half_tgl = ~s_r.half_tgl;
    unique case (s_r.config_reg[1:0])
      ICLK_BUS:      base_tick = 1'b1;
      ICLK_BUS_DIV2: base_tick = s_r.half_tgl;
      ICLK_ALT:      base_tick = s_r.alt_s2 & ~s_r.alt_s3;
      ICLK_ASYNC:    base_tick = s_r.asy_s2 & ~s_r.asy_s3;
    endcase
    div_mask = 3'((4'h1 << s_r.config_reg[6:5]) - 4'h1);
    conv_tick = base_tick && ((s_r.div_cnt & div_mask) == div_mask);
    if (base_tick)
      s_nxt.div_cnt = s_r.div_cnt + 3'h1;

    conv_val = round_code(sar_code, s_r.config_reg[3:2]);
    cmp_val  = res_mask({s_r.cv_high, s_r.cv_low}, s_r.config_reg[3:2]);
    diff_val = res_mask(conv_val + ~cmp_val + 12'h001, s_r.config_reg[3:2]);
    cmp_ge   = (conv_val >= cmp_val);
    cmp_ok   = ~s_r.cmp_en | (s_r.cmp_upper ? cmp_ge : ~cmp_ge);

    // Sequencing of one conversion
    unique case (s_r.phase)
      ST_IDLE:
      begin
        if (s_r.trig_sel && trg_rise && s_r.channel != CHANNEL_OFF)
          s_nxt = launch(s_nxt, 1'b1);
      end
      ST_STARTUP:
      begin
        if (s_r.cnt <= 6'h01)
        begin
          s_nxt.phase = ST_SAMPLE;
          s_nxt.cnt   = (s_r.config_reg[4] ? SAMPLE_LONG_CYC : SAMPLE_SHORT_CYC)
                      + FIRST_EXTRA_CYC;
        end
        else
          s_nxt.cnt = s_r.cnt - 6'h01;
      end
      ST_SAMPLE:
      begin
        if (conv_tick)
        begin
          if (s_r.cnt <= 6'h01)
          begin
            s_nxt.phase = ST_APPROX;
            s_nxt.cnt   = wide_mode ? APPROX_HI_CYC : APPROX_8BIT_CYC;
          end
          else
            s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      ST_APPROX:
      begin
        if (conv_tick)
        begin
          if (s_r.cnt <= 6'h01)
          begin
            s_nxt.phase = ST_XFER;
            s_nxt.cnt   = s_r.first ? XFER_FIRST_CYC : XFER_NEXT_CYC;
          end
          else
            s_nxt.cnt = s_r.cnt - 6'h01;
        end
      end
      ST_XFER:
      begin
        if (s_r.cnt > 6'h01)
          s_nxt.cnt = s_r.cnt - 6'h01;
        else if (!cmp_ok)
        begin
          if (s_r.cont)
            s_nxt = launch(s_nxt, 1'b0);
          else
            s_nxt = halt(s_nxt);
        end
        else if (s_r.block && wide_mode)
        begin
          s_nxt = launch(s_nxt, 1'b0);
        end
        else
        begin
          s_nxt.result = s_r.cmp_en ? diff_val : conv_val;
          s_nxt.done   = 1'b1;
          if (s_r.cont)
            s_nxt = launch(s_nxt, 1'b0);
          else
            s_nxt = halt(s_nxt);
        end
      end
    endcase

    if (stop_mode_req && s_r.config_reg[1:0] != ICLK_ASYNC)
      s_nxt = halt(s_nxt);

    // Slave answers in the second access cycle so that pready comes from a flop
    apb_acc = psel & penable & s_r.pready;
    apb_wr  = apb_acc & pwrite;
    apb_rd  = apb_acc & ~pwrite;
    s_nxt.pready  = psel & penable & ~s_r.pready;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata  = 32'h0000_0000;

    if (psel && penable && !s_r.pready)
    begin
      unique case (paddr)
        OFS_STATUS_CONTROL_ONE:
          s_nxt.prdata[7:0] = {s_r.done, s_r.irq_en, s_r.cont, s_r.channel};
        OFS_STATUS_CONTROL_TWO:
          s_nxt.prdata[7:0] = {busy, s_r.trig_sel, s_r.cmp_en, s_r.cmp_upper, 4'h0};
        OFS_RESULT_HIGH:
          s_nxt.prdata[7:0] = {4'h0, s_r.result[11:8]};
        OFS_RESULT_LOW:
          s_nxt.prdata[7:0] = s_r.result[7:0];
        OFS_COMPARE_VALUE_HIGH:
          s_nxt.prdata[7:0] = {4'h0, s_r.cv_high};
        OFS_COMPARE_VALUE_LOW:
          s_nxt.prdata[7:0] = s_r.cv_low;
        OFS_CONVERTER_CONFIG:
          s_nxt.prdata[7:0] = s_r.config_reg;
        default:
          s_nxt.pslverr = 1'b1;
      endcase
    end

    if (apb_wr)
    begin
      unique case (paddr)
        OFS_STATUS_CONTROL_ONE:
        begin
          s_nxt.irq_en  = pwdata[SC1_IRQ_EN_BIT];
          s_nxt.cont    = pwdata[SC1_CONT_BIT];
          s_nxt.channel = pwdata[4:0];
          // A completion in this very cycle keeps its flag
          if (!(s_nxt.done && !s_r.done))
            s_nxt.done = 1'b0;
          s_nxt = halt(s_nxt);
          if (!s_r.trig_sel && pwdata[4:0] != CHANNEL_OFF)
            s_nxt = launch(s_nxt, 1'b1);
        end
        OFS_STATUS_CONTROL_TWO:
        begin
          s_nxt.trig_sel  = pwdata[SC2_TRIG_BIT];
          s_nxt.cmp_en    = pwdata[SC2_CMP_EN_BIT];
          s_nxt.cmp_upper = pwdata[SC2_CMP_UP_BIT];
          s_nxt = halt(s_nxt);
        end
        OFS_COMPARE_VALUE_HIGH:
        begin
          s_nxt.cv_high = pwdata[3:0];
          s_nxt = halt(s_nxt);
        end
        OFS_COMPARE_VALUE_LOW:
        begin
          s_nxt.cv_low = pwdata[7:0];
          s_nxt = halt(s_nxt);
        end
        OFS_CONVERTER_CONFIG:
        begin
          s_nxt.config_reg = pwdata[7:0];
          s_nxt = halt(s_nxt);
        end
        default:
          s_nxt.pslverr = 1'b0;
      endcase
    end

    if (apb_rd)
    begin
      if (paddr == OFS_RESULT_HIGH && wide_mode)
        s_nxt.block = 1'b1;
      if (paddr == OFS_RESULT_LOW)
      begin
        s_nxt.block = 1'b0;
        if (!(s_nxt.done && !s_r.done))
          s_nxt.done = 1'b0;
      end
    end

    if (s_nxt.channel == CHANNEL_OFF)
      s_nxt = halt(s_nxt);

    s_nxt.sample_phase = (s_nxt.phase == ST_SAMPLE);
    s_nxt.active       = (s_nxt.phase != ST_IDLE);
    s_nxt.done_irq = s_nxt.done & s_nxt.irq_en;
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r            <= '0;
      s_r.channel    <= CHANNEL_RESET;
      s_r.config_reg <= CONFIG_RESET;
      s_r.phase      <= ST_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign prdata       = s_r.prdata;
  assign pready       = s_r.pready;
  assign pslverr      = s_r.pslverr;
  assign done_irq     = s_r.done_irq;
  assign conv_active  = s_r.active;
  assign sample_phase = s_r.sample_phase;
  assign async_clk_en = s_r.async_clk_en;
  assign channel_out  = s_r.channel;

endmodule : adcsq_sequencer

/* File: tb/adc_conversion_sequencer_tb_top.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_tb_top;
  import adcsq_pkg::*;
  logic        sys_clk, pready, pslverr, errq, hw_conversion_trigger, alt_clk_in;
  logic        async_conv_clock, done_irq, conv_active, sample_phase, async_clk_en;
  logic        rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        stop_mode_req = 1'b0, fire = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [11:0] sar_code = 12'hAB0;
  logic [4:0]  channel_out;
  logic [31:0] pwdata = 32'h0, prdata, rdq;
  int          error_cnt = 0, n_tests = 0;
  localparam logic [7:0] A1 = OFS_STATUS_CONTROL_ONE, A2 = OFS_STATUS_CONTROL_TWO;
  localparam logic [7:0] AC = OFS_CONVERTER_CONFIG, RH = OFS_RESULT_HIGH, RL = OFS_RESULT_LOW;
  localparam logic [1:0]  MD[3] = '{MODE_8BIT, MODE_10BIT, MODE_12BIT};
  localparam logic [31:0] HI[3] = '{32'h00, 32'h02, 32'h0A};
  localparam logic [31:0] LO[3] = '{32'hAB, 32'hAC, 32'hB0};
  localparam logic [31:0] CK[2] = '{32'h07, 32'h76};
  adcsq_sequencer i_adcsq_sequencer (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .hw_conversion_trigger(hw_conversion_trigger), .alt_clk_in(alt_clk_in),
    .async_conv_clock(async_conv_clock), .stop_mode_req(stop_mode_req),
    .sar_code(sar_code), .done_irq(done_irq), .conv_active(conv_active),
    .sample_phase(sample_phase), .async_clk_en(async_clk_en), .channel_out(channel_out)
  );
  adcsq_trig_src i_adcsq_trig_src (
    .sys_clk(sys_clk), .rstn(rstn), .fire(fire), .hw_conversion_trigger(hw_conversion_trigger),
    .alt_clk_in(alt_clk_in), .async_conv_clock(async_conv_clock)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdq     = prdata;
    errq    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 32'h1, 32'(n < 20));
    if (n >= 20)
      stop_test();
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdq);
  endtask : rd
  task automatic wait_done(input int lim);
    int n;
    n = 0;
    repeat (2) @(posedge sys_clk);
    while (done_irq !== 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk("done_irq", 32'h1, 32'(n < lim));
    if (n >= lim)
      stop_test();
  endtask : wait_done
  // Output is sampled after the wait, not when the task is called
  task automatic idle(input int n, input string nm, input bit act);
    repeat (n) @(posedge sys_clk);
    chk(nm, 32'h0, act ? {31'h0, conv_active} : {31'h0, done_irq});
  endtask : idle
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(A1, 32'h1F, "sc1_reset");
    rd(AC, 32'h00, "cfg_reset");
    rd(8'h40, 32'h00, "unmapped");
    chk("slverr", 32'h1, errq);
    $display("test reset finished");
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, AC, {28'h0, MD[i], 2'h0});
      apb(1'b1, A1, 32'h43);
      wait_done(400);
      chk("channel", 32'h3, channel_out);
      rd(RH, HI[i], "res_high");
      rd(RL, LO[i], "res_low");
      idle(2, "done_clear", 1'b0);
    end
    $display("test resolution finished");
    sar_code <= 12'h123;
    apb(1'b1, A1, 32'h43);
    repeat (5) @(posedge sys_clk);
    apb(1'b1, AC, 32'h04);
    idle(60, "abort_done", 1'b0);
    rd(RH, 32'h0A, "abort_high");
    rd(RL, 32'hB0, "abort_low");
    sar_code <= 12'hAB0;
    apb(1'b1, OFS_COMPARE_VALUE_HIGH, 32'h01);
    apb(1'b1, OFS_COMPARE_VALUE_LOW, 32'h00);
    apb(1'b1, A2, 32'h30);
    apb(1'b1, A1, 32'h43);
    wait_done(400);
    rd(RH, 32'h09, "diff_high");
    rd(RL, 32'hB0, "diff_low");
    sar_code <= 12'h123;
    apb(1'b1, OFS_COMPARE_VALUE_HIGH, 32'h0B);
    apb(1'b1, A1, 32'h43);
    idle(100, "cmp_false", 1'b0);
    rd(RH, 32'h09, "kept_high");
    rd(RL, 32'hB0, "kept_low");
    apb(1'b1, A2, 32'h20);
    apb(1'b1, A1, 32'h43);
    wait_done(400);
    rd(RH, 32'h06, "lower_high");
    rd(RL, 32'h23, "lower_low");
    $display("test compare finished");
    apb(1'b1, A2, 32'h00);
    sar_code <= 12'hAB0;
    apb(1'b1, A1, 32'h43);
    repeat (5) @(posedge sys_clk);
    stop_mode_req <= 1'b1;
    idle(3, "stop_abort", 1'b1);
    stop_mode_req <= 1'b0;
    idle(60, "stop_done", 1'b0);
    apb(1'b1, A1, 32'h43);
    // Early high-byte read on purpose to arm the lock
    apb(1'b0, RH, 32'h0);
    idle(60, "lock_done", 1'b0);
    chk("lock_busy", 32'h1, conv_active);
    apb(1'b0, RL, 32'h0);
    wait_done(400);
    rd(RH, 32'h0A, "lock_high");
    rd(RL, 32'hB0, "lock_low");
    $display("test abort and lock finished");
    apb(1'b1, A2, 32'h40);
    apb(1'b1, A1, 32'h43);
    idle(20, "hw_wait", 1'b1);
    for (int k = 0; k < 2; k++)
    begin
      fire <= 1'b1;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (10) @(posedge sys_clk);
    end
    wait_done(400);
    apb(1'b0, RL, 32'h0);
    idle(40, "hw_ignored", 1'b1);
    chk("hw_no_queue", 32'h0, done_irq);
    apb(1'b1, A2, 32'h00);
    foreach (CK[i])
    begin
      apb(1'b1, AC, CK[i]);
      apb(1'b1, A1, 32'h43);
      idle(40, "slow_done", 1'b0);
      chk("async_en", {31'h0, CK[i][1:0] == ICLK_ASYNC}, async_clk_en);
      wait_done(3000);
    end
    $display("test trigger and clocks finished");
    apb(1'b1, AC, 32'h04);
    apb(1'b1, A1, 32'h63);
    wait_done(400);
    apb(1'b0, RL, 32'h0);
    wait_done(400);
    apb(1'b1, A1, 32'h1F);
    idle(3, "off_idle", 1'b1);
    chk("off_chan", 32'h1F, channel_out);
    $display("test continuous finished");
    // Reset in mid conversion: abort and results back to reset values
    apb(1'b1, A1, 32'h43);
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("rst_abort", 32'h0, conv_active);
    rstn <= 1'b1;
    rd(RH, 32'h00, "rst_high");
    rd(RL, 32'h00, "rst_low");
    chk("rst_chan", 32'h1F, channel_out);
    $display("test reset abort finished");
    stop_test();
  end
endmodule : adc_conversion_sequencer_tb_top

/* File: tb/adcsq_chk.sv */
// Port checker for the conversion sequencer
`timescale 1ns/1ps
module adcsq_chk
  import adcsq_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        hw_conversion_trigger,
  input wire logic        stop_mode_req,
  input wire logic        done_irq,
  input wire logic        conv_active,
  input wire logic        sample_phase,
  input wire logic        async_clk_en,
  input wire logic [4:0]  channel_out
);
  logic hw_sel_r;
  logic wr_ok;
  logic sc1_wr;
  logic cfg_wr;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  assign wr_ok  = psel && penable && pready && pwrite;
  assign sc1_wr = wr_ok && paddr == OFS_STATUS_CONTROL_ONE;
  assign cfg_wr = wr_ok && paddr inside {OFS_STATUS_CONTROL_TWO, OFS_CONVERTER_CONFIG,
                  OFS_COMPARE_VALUE_HIGH, OFS_COMPARE_VALUE_LOW};
  // Trigger select is not a port, so it is shadowed from bus writes
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      hw_sel_r <= 1'b0;
    else if (wr_ok && paddr == OFS_STATUS_CONTROL_TWO)
      hw_sel_r <= pwdata[SC2_TRIG_BIT];
  property p_sw_start;
    sc1_wr && pwdata[4:0] != CHANNEL_OFF && !hw_sel_r |-> ##[1:2] conv_active;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("no start after write");
  property p_off_idle;
    sc1_wr && pwdata[4:0] == CHANNEL_OFF |-> ##[1:2] !conv_active;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("busy with channel off");
  property p_cfg_abort;
    cfg_wr |=> !conv_active;
  endproperty
  a_cfg_abort: assert property (p_cfg_abort) else $error("no abort on write");
  property p_stop_abort;
    $rose(stop_mode_req) && !async_clk_en |-> ##[1:2] !conv_active;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("no abort on stop");
  property p_disabled;
    $stable(channel_out) && channel_out == CHANNEL_OFF |-> !conv_active;
  endproperty
  a_disabled: assert property (p_disabled) else $error("active while off");
  property p_hw_start;
    $rose(hw_conversion_trigger) && hw_sel_r && !conv_active && channel_out != CHANNEL_OFF
      |=> !conv_active ##[1:6] conv_active;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("trigger start wrong");
  property p_done_end;
    $rose(done_irq) |-> $past(conv_active) || $past(conv_active, 2);
  endproperty
  a_done_end: assert property (p_done_end) else $error("done without conversion");
  property p_sample_in;
    sample_phase |-> conv_active;
  endproperty
  a_sample_in: assert property (p_sample_in) else $error("sample while idle");
  property p_async_idle;
    !conv_active [*2] |-> !async_clk_en;
  endproperty
  a_async_idle: assert property (p_async_idle) else $error("async clock on idle");
endmodule : adcsq_chk

bind adcsq_sequencer adcsq_chk i_adcsq_chk (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .stop_mode_req(stop_mode_req),
  .hw_conversion_trigger(hw_conversion_trigger), .done_irq(done_irq),
  .conv_active(conv_active), .sample_phase(sample_phase), .async_clk_en(async_clk_en),
  .channel_out(channel_out)
);

/* File: tb/adcsq_trig_src.sv */
// Trigger source and slow clock sources beside the sequencer
`timescale 1ns/1ps
module adcsq_trig_src
(
  input  wire logic sys_clk,
  input  wire logic rstn,
  input  wire logic fire,
  output logic      hw_conversion_trigger,
  output logic      alt_clk_in,
  output logic      async_conv_clock
);
  logic [2:0] hold_r;
  logic [2:0] div_r;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hold_r <= 3'h0;
      div_r  <= 3'h0;
    end
    else
    begin
      div_r  <= div_r + 3'h1;
      hold_r <= fire ? 3'h4 : (hold_r != 3'h0 ? hold_r - 3'h1 : 3'h0);
    end
  end
  assign hw_conversion_trigger = hold_r != 3'h0;
  assign alt_clk_in            = div_r[1];
  assign async_conv_clock      = div_r[2];
endmodule : adcsq_trig_src
